/* hdl/adc_conversion_sequencer.sv */
// Function
// - Clearing start/done mid-conversion aborts the conversion at once.
// - An aborted conversion leaves the result register untouched.
// - After an abort wait two bit periods, then acquire the selected channel.
// - Completion sets the done flag and clears start/done.
// - Conversion lasts 1.5 bit periods of setup plus one bit period for each of the 8 bits.
// - Acquisition length does not depend on chosen resolution.
// - Converter runs in sleep only with the RC clock selected.
// - With RC clock, wait one instruction cycle after start before converting.
// - Completion in sleep loads result; wake if enabled, else power down.
// - Sleep with a divided clock aborts and powers down, power bit kept.
// - Any reset clears control, powers off and aborts.
// - Reset leaves the result register unmodified.
// - An 8-bit conversion takes nine and a half bit periods.
// - Clock select gives 2, 8, 32 oscillator periods or the RC clock.
// - After completion hold off acquisition two bit periods, input disconnected.
`timescale 1ns/100ps
`include "adc_seq_regs.svh"

module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Core power state
	input  wire logic        sleep_i,
	output logic             wake_o,
	// Analog front end
	input  wire logic        comparator_i,
	input  wire logic        rc_tick_i,
	output logic [7:0]       trial_code_o,
	output logic [2:0]       channel_select_o,
	output logic             sample_o,
	output logic             analog_on_o
);

	conv_state_t state;
	conv_state_t next_state;

	logic [1:0] conv_clock_select;
	logic [2:0] channel_select;
	logic       conv_power_on;
	logic       conv_done_flag;
	logic       conv_irq_enable;
	logic [7:0] conv_result;
	logic       powered_down;
	logic       busy;

	logic       bus_req;
	logic       wr_req;
	logic       wr_ctrl;
	logic       wr_result;
	logic       wr_flag;
	logic       start_req;
	logic       abort_req;
	logic       sleep_abort;
	logic       go_conv;
	logic [2:0] wait_count;
	logic [2:0] hold_count;
	logic       half_tick;
	logic       sar_done;
	logic [7:0] sar_result;
	logic [7:0] sar_trial;

	// Register decode helper
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction

	// Bus strobes; a write lands at the edge where ack is high, only lane 0 holds bits
	always_comb
	begin
		bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wr_req    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
		wr_ctrl   = wr_req && hit(wb_adr_i, `CONV_CTRL_OFS);
		wr_result = wr_req && hit(wb_adr_i, `CONV_RESULT_OFS);
		wr_flag   = wr_req && hit(wb_adr_i, `CONV_FLAG_OFS);
	end

	// Conversion requests
	always_comb
	begin
		busy        = (state == ST_START_WAIT) || (state == ST_CONV);
		// Start needs the converter already on (power and start in one write is ignored)
		start_req   = wr_ctrl && wb_dat_i[`CONV_CTRL_GO_BIT] && conv_power_on
			&& wb_dat_i[`CONV_CTRL_PWR_BIT] && !powered_down && state == ST_ACQ;
		sleep_abort = sleep_i && conv_clock_select != CSEL_RC && busy;
		abort_req   = busy && (sleep_abort || (wr_ctrl && !wb_dat_i[`CONV_CTRL_GO_BIT]));
		go_conv     = state == ST_START_WAIT && wait_count == 3'h0 && !abort_req;
	end

	// Next state
	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
				if (conv_power_on && !powered_down)
					next_state = ST_ACQ;
			ST_ACQ:
				if (start_req)
					next_state = ST_START_WAIT;
			ST_START_WAIT:
				if (abort_req)
					next_state = ST_HOLD;
				else if (go_conv)
					next_state = ST_CONV;
			ST_CONV:
				if (abort_req)
					next_state = ST_HOLD;
				else if (sar_done)
					next_state = ST_HOLD;
			ST_HOLD:
				if (half_tick && hold_count == 3'(`CONV_HALF_HOLDOFF - 1))
					next_state = ST_ACQ;
			default:
				next_state = ST_OFF;
		endcase
		if (!conv_power_on || powered_down)
			next_state = ST_OFF;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_OFF;
		else
			state <= next_state;
	end

	// One instruction cycle wait with RC clock, none otherwise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wait_count <= 3'h0;
		else if (start_req)
			wait_count <= (conv_clock_select == CSEL_RC) ? 3'(`CONV_INSTR_CYCLES - 1) : 3'h0;
		else if (wait_count != 3'h0)
			wait_count <= wait_count - 3'h1;
	end

	// Holdoff count in half bit periods
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state != ST_HOLD)
			hold_count <= 3'h0;
		else if (half_tick)
			hold_count <= hold_count + 3'h1;
	end

	// Control register; start/done is the busy state itself
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conv_power_on     <= 1'(`CONV_CTRL_RESET >> `CONV_CTRL_PWR_BIT);
			conv_clock_select <= 2'h0;
			channel_select    <= 3'h0;
		end
		else if (wr_ctrl)
		begin
			conv_power_on     <= wb_dat_i[`CONV_CTRL_PWR_BIT];
			conv_clock_select <= wb_dat_i[`CONV_CTRL_CKS_MSB:`CONV_CTRL_CKS_LSB];
			channel_select    <= wb_dat_i[`CONV_CTRL_CHS_MSB:`CONV_CTRL_CHS_LSB];
		end
	end

	// Module off in sleep with power bit kept; cleared once the core wakes
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !sleep_i)
			powered_down <= 1'b0;
		else if (conv_power_on && conv_clock_select != CSEL_RC)
			powered_down <= 1'b1;
		else if (sar_done && state == ST_CONV && !conv_irq_enable)
			powered_down <= 1'b1;
	end

	// Done flag: hardware set wins over a software clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conv_done_flag  <= 1'b0;
			conv_irq_enable <= 1'b0;
		end
		else
		begin
			if (wr_flag)
				conv_irq_enable <= wb_dat_i[`CONV_FLAG_IEN_BIT];
			if (sar_done && state == ST_CONV)
				conv_done_flag <= 1'b1;
			else if (wr_flag && wb_dat_i[`CONV_FLAG_DONE_BIT])
				conv_done_flag <= 1'b0;
		end
	end

	// Result register has no reset; only completion or software writes it
	always_ff @(posedge clk_i)
	begin
		if (sar_done && state == ST_CONV)
			conv_result <= sar_result;
		else if (wr_result)
			conv_result <= wb_dat_i[7:0];
	end

	// Bus answer one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i)
			begin
				if (hit(wb_adr_i, `CONV_CTRL_OFS))
					wb_dat_o <= {24'h00_0000, conv_clock_select, channel_select,
						busy, 1'b0, conv_power_on};
				else if (hit(wb_adr_i, `CONV_RESULT_OFS))
					wb_dat_o <= {24'h00_0000, conv_result};
				else if (hit(wb_adr_i, `CONV_FLAG_OFS))
					wb_dat_o <= {30'h0000_0000, conv_irq_enable, conv_done_flag};
				else if (hit(wb_adr_i, `CONV_STATUS_OFS))
					wb_dat_o <= {29'h0000_0000, sample_o, powered_down, busy};
			end
		end
	end

	// Bit clock runs while converting or holding off
	conv_bit_clock u_bit_clock (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.run_i          (state == ST_CONV || state == ST_HOLD),
		.clock_select_i (conv_clock_select),
		.rc_tick_i      (rc_tick_i),
		.half_tick_o    (half_tick)
	);

	// Successive approximation
	conv_sar_core u_sar_core (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.start_i      (go_conv),
		.abort_i      (abort_req || state == ST_OFF),
		.half_tick_i  (half_tick),
		.comparator_i (comparator_i),
		.trial_code_o (sar_trial),
		.result_o     (sar_result),
		.done_o       (sar_done)
	);

	// Front end outputs; sampling only in acquisition, independent of resolution
	always_comb
	begin
		trial_code_o     = sar_trial;
		channel_select_o = channel_select;
		sample_o         = (state == ST_ACQ);
		analog_on_o      = conv_power_on && !powered_down;
		wake_o           = sleep_i && conv_done_flag && conv_irq_enable;
	end

	// Helper: cycles spent in conversion and whether the clock stayed at 2 Tosc
	logic [9:0] conv_len;
	logic       conv_all_div2;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state != ST_CONV)
		begin
			conv_len      <= 10'h000;
			conv_all_div2 <= (conv_clock_select == CSEL_DIV2);
		end
		else
		begin
			conv_len <= conv_len + 10'h001;
			if (conv_clock_select != CSEL_DIV2)
				conv_all_div2 <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_abort_to_hold: assert property (abort_req |=> state == ST_HOLD && !busy)
		else $error("abort did not stop the conversion");
	a_abort_keep_result: assert property (abort_req |=> $stable(conv_result))
		else $error("aborted conversion changed the result");
	a_hold_then_acq: assert property ((state == ST_HOLD && half_tick
		&& hold_count == 3'h3) |=> state == ST_ACQ)
		else $error("holdoff did not return to acquisition");
	a_done_flag_set: assert property ((sar_done && state == ST_CONV)
		|=> conv_done_flag && !busy && conv_result == $past(sar_result))
		else $error("completion did not set flag and load result");
	a_rc_start_wait: assert property ((start_req && conv_clock_select == CSEL_RC
		&& !sleep_i) |=> (state == ST_START_WAIT)[*4] ##1 state == ST_CONV)
		else $error("RC start delay is not one instruction cycle");
	a_sleep_done_down: assert property ((sleep_i && sar_done && state == ST_CONV
		&& !conv_irq_enable) |=> powered_down && conv_power_on && !analog_on_o)
		else $error("sleep completion did not power down");
	a_sleep_abort_off: assert property (sleep_abort |=> !busy && powered_down
		&& conv_power_on)
		else $error("sleep with divided clock did not abort");
	a_reset_off: assert property (@(posedge clk_i) $fell(rst_i) |-> state == ST_OFF
		&& !conv_power_on && !conv_done_flag)
		else $error("reset did not turn the converter off");
	a_conv_length: assert property ((sar_done && conv_all_div2 && state == ST_CONV)
		|-> conv_len == 10'h013)
		else $error("full conversion at 2 Tosc is not 9.5 bit periods");
	a_hold_no_sample: assert property (state == ST_HOLD |-> !sample_o)
		else $error("input connected during holdoff");
	a_start_busy: assert property (start_req |=> busy)
		else $error("start did not make the converter busy");
	a_rc_wake: assert property (sleep_i && sar_done && state == ST_CONV && conv_irq_enable
		|=> wake_o)
		else $error("sleep completion did not wake the core");
	a_power_down_idle: assert property (!conv_power_on || powered_down
		|=> state == ST_OFF)
		else $error("converter not off while unpowered");

	c_full_conversion: cover property (sar_done && state == ST_CONV);
	c_abort: cover property (abort_req && state == ST_CONV);
	c_sleep_wake: cover property (sleep_i && sar_done && conv_irq_enable);
	c_clock_switch: cover property (state == ST_CONV && $changed(conv_clock_select));
	c_sleep_down: cover property (sleep_i && sar_done && state == ST_CONV && !conv_irq_enable);

endmodule

/* hdl/adc_seq_regs.svh */
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register byte offsets on the bus
`define CONV_CTRL_OFS       8'h00
`define CONV_RESULT_OFS     8'h04
`define CONV_FLAG_OFS       8'h08
`define CONV_STATUS_OFS     8'h0c

// Control register fields
`define CONV_CTRL_PWR_BIT   0
`define CONV_CTRL_GO_BIT    2
`define CONV_CTRL_CHS_LSB   3
`define CONV_CTRL_CHS_MSB   5
`define CONV_CTRL_CKS_LSB   6
`define CONV_CTRL_CKS_MSB   7
`define CONV_CTRL_RESET     8'h00

// Flag register fields
`define CONV_FLAG_DONE_BIT  0
`define CONV_FLAG_IEN_BIT   1

// Status register fields
`define CONV_STAT_BUSY_BIT  0
`define CONV_STAT_DOWN_BIT  1
`define CONV_STAT_SAMP_BIT  2

// Bit period in oscillator periods for the three divided clocks
`define CONV_DIV2_TOSC      2
`define CONV_DIV8_TOSC      8
`define CONV_DIV32_TOSC     32

// Conversion sequence in half bit periods
`define CONV_HALF_SETUP     3
`define CONV_HALF_TOTAL     19
`define CONV_HALF_HOLDOFF   4

// Instruction cycle wait before an RC clocked conversion
`define CONV_CLK_PERIOD_NS  100
`define CONV_INSTR_NS       400
`define CONV_INSTR_CYCLES   ((`CONV_INSTR_NS + `CONV_CLK_PERIOD_NS - 1) / `CONV_CLK_PERIOD_NS)

`endif

/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_ACQ,
		ST_START_WAIT,
		ST_CONV,
		ST_HOLD
	} conv_state_t;

	// Conversion clock select codes
	typedef enum logic [1:0] {
		CSEL_DIV2  = 2'h0,
		CSEL_DIV8  = 2'h1,
		CSEL_DIV32 = 2'h2,
		CSEL_RC    = 2'h3
	} conv_clk_sel_t;

endpackage

/* hdl/conv_bit_clock.sv */
`timescale 1ns/100ps
`include "adc_seq_regs.svh"

module conv_bit_clock
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       run_i,
	input  wire logic [1:0] clock_select_i,
	input  wire logic       rc_tick_i,
	// Half bit period tick
	output logic            half_tick_o
);

	logic [4:0] div_count;
	logic [4:0] half_len;

	// Half bit period in oscillator periods for a divided clock
	function automatic logic [4:0] half_div(input logic [1:0] sel);
		case (sel)
			CSEL_DIV2:  half_div = 5'(`CONV_DIV2_TOSC / 2);
			CSEL_DIV8:  half_div = 5'(`CONV_DIV8_TOSC / 2);
			default:    half_div = 5'(`CONV_DIV32_TOSC / 2);
		endcase
	endfunction

	// Tick source: divider or the internal RC oscillator
	always_comb
	begin
		half_len    = half_div(clock_select_i);
		half_tick_o = 1'b0;
		if (run_i)
		begin
			if (clock_select_i == CSEL_RC)
				half_tick_o = rc_tick_i;
			else
				half_tick_o = (div_count >= half_len - 5'h01);
		end
	end

	// Divider count; a clock switch takes effect at once
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_i || half_tick_o)
			div_count <= 5'h00;
		else if (clock_select_i != CSEL_RC)
			div_count <= div_count + 5'h01;
	end

endmodule

/* hdl/conv_sar_core.sv */
`timescale 1ns/100ps
`include "adc_seq_regs.svh"

module conv_sar_core
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Sequencing
	input  wire logic       start_i,
	input  wire logic       abort_i,
	input  wire logic       half_tick_i,
	input  wire logic       comparator_i,
	// Results
	output logic [7:0]      trial_code_o,
	output logic [7:0]      result_o,
	output logic            done_o
);

	logic       active;
	logic [4:0] phase;
	logic [7:0] sar;
	logic [7:0] bit_mask;
	logic       in_bits;

	// Bit under trial follows the half period count
	always_comb
	begin
		in_bits  = active && (phase >= 5'(`CONV_HALF_SETUP));
		bit_mask = 8'h80 >> 3'((phase - 5'(`CONV_HALF_SETUP)) >> 1);
		trial_code_o = in_bits ? (sar | bit_mask) : sar;
	end

	// Phase counting and bit decisions; an abort drops the partial code
	always_ff @(posedge clk_i)
	begin
		if (rst_i || abort_i)
		begin
			active <= 1'b0;
			phase  <= 5'h00;
			sar    <= 8'h00;
		end
		else if (start_i)
		begin
			active <= 1'b1;
			phase  <= 5'h00;
			sar    <= 8'h00;
		end
		else if (active && half_tick_i)
		begin
			phase <= phase + 5'h01;
			if (in_bits && !phase[0] && comparator_i)
				sar <= sar | bit_mask;
			if (phase == 5'(`CONV_HALF_TOTAL - 1))
				active <= 1'b0;
		end
	end

	// Final code and completion pulse
	always_ff @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (rst_i || abort_i)
			done_o <= 1'b0;
		else if (active && half_tick_i && phase == 5'(`CONV_HALF_TOTAL - 1))
		begin
			done_o   <= 1'b1;
			result_o <= comparator_i ? (sar | bit_mask) : sar;
		end
	end

endmodule

/* tb/adc_front_model.sv */
`timescale 1ns/100ps

module adc_front_model
(
	// Clock
	input  wire logic       clk_i,
	// Analog side
	input  wire logic [7:0] vin_i,
	input  wire logic [2:0] chan_i,
	input  wire logic [7:0] trial_i,
	output logic            comp_o,
	output logic            rc_tick_o
);
	logic [2:0] cnt = 3'h0;

	// Ideal comparator; the channel number skews the level so a wrong mux shows
	assign comp_o = ((vin_i ^ {5'h0, chan_i}) >= trial_i);

	// Free running RC oscillator, one half bit period every six clocks
	always_ff @(posedge clk_i)
	begin
		cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
		rc_tick_o <= (cnt == 3'h5);
	end
endmodule

/* tb/adc_conversion_sequencer_tb_top.sv */
`timescale 1ns/100ps

module adc_conversion_sequencer_tb_top;
	import adc_seq_pkg::*;

	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        sleep_i;
	logic        wake;
	logic        comp;
	logic        rc_tick;
	logic [7:0]  trial;
	logic [2:0]  chan;
	logic        samp;
	logic        aon;
	logic [7:0]  vin;
	logic [31:0] rd;
	int          fails;
	int          n_compared;

	adc_conversion_sequencer adc_conversion_sequencer_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sleep_i(sleep_i), .wake_o(wake), .comparator_i(comp), .rc_tick_i(rc_tick),
		.trial_code_o(trial), .channel_select_o(chan), .sample_o(samp), .analog_on_o(aon)
	);

	adc_front_model adc_front_model_i (
		.clk_i(clk_i), .vin_i(vin), .chan_i(chan), .trial_i(trial), .comp_o(comp),
		.rc_tick_o(rc_tick)
	);

	// Clock source
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task give_verdict;
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic single Wishbone cycle, held until ack is sampled
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fails++;
			give_verdict();
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(a, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask

	// Poll one status bit until it reaches a level
	task wait_stat(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			wb(8'h0c, 1'b0, 32'h0);
			n++;
		end
		while (rd[b] !== v && n < 300);
		if (n >= 300)
		begin
			fails++;
			give_verdict();
		end
	endtask

	task t_reset;
		rdc(8'h00, 32'h0, "ctrl");
		rdc(8'h08, 32'h0, "flag");
		rdc(8'h0c, 32'h0, "status");
		rdc(8'h10, 32'h0, "unmapped");
		chk("analog on", 32'h0, aon);
	endtask

	// Start in the power-on write must be ignored
	task t_same_write;
		wb(8'h00, 1'b1, 32'h05);
		rdc(8'h00, 32'h01, "ctrl same write");
	endtask

	task t_convert(input logic [1:0] cs, input logic [2:0] ch, input logic [7:0] v);
		vin <= v;
		wb(8'h00, 1'b1, {24'h0, cs, ch, 3'b001});
		wait_stat(2, 1'b1);
		wb(8'h00, 1'b1, {24'h0, cs, ch, 3'b101});
		rdc(8'h00, {24'h0, cs, ch, 3'b101}, "busy");
		wait_stat(0, 1'b0);
		if (cs != 2'h0)
			chk("holdoff sample", 32'h0, samp);
		rdc(8'h04, {24'h0, v ^ {5'h0, ch}}, "result");
		rdc(8'h08, 32'h1, "flag");
		rdc(8'h00, {24'h0, cs, ch, 3'b001}, "done bit");
		wb(8'h08, 1'b1, 32'h1);
		rdc(8'h08, 32'h0, "flag clear");
	endtask

	task t_abort(input logic [7:0] prev);
		vin <= 8'h33;
		wait_stat(2, 1'b1);
		wb(8'h00, 1'b1, 32'h05);
		wb(8'h00, 1'b1, 32'h01);
		rdc(8'h0c, 32'h0, "abort status");
		rdc(8'h04, {24'h0, prev}, "abort result");
		rdc(8'h08, 32'h0, "abort flag");
		wait_stat(2, 1'b1);
		chk("reacquire", 32'h1, samp);
	endtask

	// Sleep with a divided clock aborts and powers down
	task t_sleep_div;
		wb(8'h00, 1'b1, 32'h81);
		wait_stat(2, 1'b1);
		wb(8'h00, 1'b1, 32'h85);
		sleep_i <= 1'b1;
		rdc(8'h0c, 32'h2, "sleep status");
		rdc(8'h00, 32'h81, "power kept");
		chk("sleep analog", 32'h0, aon);
		sleep_i <= 1'b0;
	endtask

	// RC clocked conversion in sleep wakes the core
	task t_sleep_rc;
		int n;
		wb(8'h08, 1'b1, 32'h2);
		wb(8'h00, 1'b1, 32'hc1);
		wait_stat(2, 1'b1);
		vin <= 8'h5a;
		wb(8'h00, 1'b1, 32'hc5);
		sleep_i <= 1'b1;
		n = 0;
		while (wake !== 1'b1 && n < 500)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("wake", 32'h1, wake);
		rdc(8'h04, 32'h5a, "sleep result");
		rdc(8'h00, 32'hc1, "sleep done bit");
		sleep_i <= 1'b0;
		wb(8'h08, 1'b1, 32'h1);
		// Same in sleep with the interrupt off: no wake, converter powers down
		wait_stat(2, 1'b1);
		wb(8'h00, 1'b1, 32'hc5);
		sleep_i <= 1'b1;
		wait_stat(1, 1'b1);
		chk("no wake", 32'h0, wake);
		rdc(8'h04, 32'h5a, "quiet sleep result");
		rdc(8'h00, 32'hc1, "quiet power kept");
		rdc(8'h08, 32'h1, "quiet flag");
		sleep_i <= 1'b0;
		wb(8'h08, 1'b1, 32'h1);
	endtask

	task t_reset_mid;
		wb(8'h00, 1'b1, 32'h41);
		wait_stat(2, 1'b1);
		wb(8'h00, 1'b1, 32'h45);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(8'h00, 32'h0, "ctrl after reset");
		rdc(8'h0c, 32'h0, "status after reset");
		chk("analog after reset", 32'h0, aon);
	endtask

	// Main sequence
	initial
	begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'h1;
		wdat = 32'h0;
		sleep_i = 1'b0;
		vin = 8'h0;
		fails = 0;
		n_compared = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_same_write();
		t_convert(2'h1, 3'h3, 8'ha7);
		t_convert(2'h2, 3'h0, 8'h01);
		t_convert(2'h0, 3'h0, 8'hfe);
		t_abort(8'hfe);
		t_sleep_div();
		t_sleep_rc();
		t_reset_mid();
		give_verdict();
	end
endmodule
